//--- shared/pbs_pkg.sv
// Package: constants and types for the page batch scheduler controller
package pbs_pkg;
   localparam int CLK_HZ = 20000000;
   localparam int SEC_TICK_CYCLES = CLK_HZ;
   localparam int SEC_PER_MIN = 60;
   localparam int MIN_PER_CYCLE = 4;
   localparam int ACT_HOLD_MS = 50;
   localparam int ACT_HOLD_CYCLES = (CLK_HZ / 1000) * ACT_HOLD_MS;
   localparam int LOCK_LOSS_S = 3;
   localparam int DEST_ENTRIES = 8;
   localparam int DEST_W = 16;
   localparam int BUF_DEPTH = 16;
   localparam int BUF_AW = 4;
   localparam int PAGE_W = 32;
   localparam int TAG_W = 28;
   localparam int TAG_SYS_W = 12;
   localparam int CMD_ACK_W = 28;

   // APB register byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_TAG = 8'h08;
   localparam logic [7:0] ADDR_DEST0 = 8'h10;
   localparam logic [7:0] ADDR_PAGE_IN = 8'h30;
   localparam logic [7:0] ADDR_REMOTE_CONFIG_REQUEST = 8'h34;
   localparam logic [7:0] ADDR_CMDACK = 8'h38;
   localparam logic [7:0] ADDR_TIMEPKT = 8'h3C;
   localparam logic [7:0] ADDR_TX_OUT = 8'h40;

   // CTRL fields
   localparam int CTRL_ROLE_LO = 0;
   localparam int CTRL_CHAN2 = 2;
   localparam int CTRL_MIX_SYNC = 3;
   localparam int CTRL_MODE_OUT = 4;
   localparam int CTRL_SRC_GPS = 5;
   localparam logic [5:0] CTRL_RESET = 6'h00;

   // Page word fields: kind in top two bits, destination in low 16
   localparam int PG_KIND_HI = 31;
   localparam int PG_KIND_LO = 30;

   typedef enum logic [1:0] {PBS_ROLE_SLAVE, PBS_ROLE_MASTER, PBS_ROLE_MS, PBS_ROLE_SYNC} pbs_role_t;
   typedef enum logic [1:0] {PBS_KIND_POCSAG, PBS_KIND_GOLAY, PBS_KIND_SYNC4, PBS_KIND_CMD} pbs_kind_t;
endpackage

//--- verilog/pbs_page_mem.sv
// Page buffer memory with registered read data
`timescale 1ns/100ps
module pbs_page_mem (
   input wire logic clk,
   input wire logic we,
   input wire logic [pbs_pkg::BUF_AW-1:0] waddr,
   input wire logic [pbs_pkg::PAGE_W-1:0] wdata,
   input wire logic [pbs_pkg::BUF_AW-1:0] raddr,
   output logic [pbs_pkg::PAGE_W-1:0] rdata
);
   logic [pbs_pkg::PAGE_W-1:0] mem [pbs_pkg::BUF_DEPTH];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule // pbs_page_mem

//--- verilog/pbs_activity.sv
// Activity indicator: synchronised input, stretched on any edge
`timescale 1ns/100ps
module pbs_activity (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic din,
   output logic led
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic [31:0] cnt_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
         s3_q <= 1'b1;
      end else begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Stretch so a single start bit stays visible
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 32'h0;
         led <= 1'b0;
      end else begin
         if (s2_q != s3_q) begin
            cnt_q <= 32'(pbs_pkg::ACT_HOLD_CYCLES);
         end else if (cnt_q != 32'h0) begin
            cnt_q <= cnt_q - 32'h1;
         end
         led <= (s2_q != s3_q) || (cnt_q != 32'h0);
      end
   end
endmodule // pbs_activity

//--- verilog/pbs_top.sv
// Paging controller core: filter, buffer, batch scheduler, status indicators
`timescale 1ns/100ps
// Operation
// - Master lights command indicator after sending command, clears on acknowledge.
// - Sync indicator lit only while locked to selected time source.
// - Separate activity for console, aux, two paging inputs; aux stays dark.
// - Push-to-talk indicator follows each port's push-to-talk line exactly.
// - Master-slave role holds busy and error indicators inactive.
// - Select indicators copy select lines; lines toggle only with multiple channels.
// - Two channels: second select asserted while second channel chosen.
// - Mode indicator lit whenever mode line toward exciter asserted.
// - Master wraps console commands into frames merged into outgoing stream.
// - Remote command accepted only in master role; tag then command text.
// - Pages whose destination is not in the table are discarded.
// - Matching pages stored in buffer in modified internal form.
// - Like-kind batches sent back to back; minute count repeats on a four-minute cycle.
// - Golay/POCSAG: send all of oldest kind, then oldest other kind.
// - Sync format mixed: sync pages at minute start, POCSAG fills rest.
// - Local time base locked to received time packets only.
// - Seven-digit command tag: three system digits, four unit digits.
module pbs_top (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic CONSOLE_RXD,
   input wire logic AUX_RXD,
   input wire logic PAGING_IN_ONE_RXD,
   input wire logic PAGING_IN_TWO_RXD,
   output logic PWR_LED,
   output logic CMD_LED,
   output logic SYNC_LED,
   output logic COMM_LED,
   output logic AUX_LED,
   output logic PAGING_INPUT_ONE_LED,
   output logic PAGING_INPUT_TWO_LED,
   output logic [1:0] BUSY_LED,
   output logic [1:0] ERROR_LED,
   output logic [1:0] PTT_LED,
   output logic [1:0] PTT_OUT,
   output logic [1:0] CHANNEL_SELECT_ONE,
   output logic [1:0] CHANNEL_SELECT_TWO,
   output logic [1:0] SEL_ONE_LED,
   output logic [1:0] SEL_TWO_LED,
   output logic MODE_OUT,
   output logic MODE_LED
);
   ////////////////////////////////////////////////////////////////////////
   logic [5:0] ctrl_q;
   logic [pbs_pkg::TAG_W-1:0] tag_q;
   logic [pbs_pkg::DEST_W-1:0] dest_q [pbs_pkg::DEST_ENTRIES];
   logic [pbs_pkg::DEST_ENTRIES-1:0] dest_vld_q;
   logic cmd_pend_q;
   logic [pbs_pkg::PAGE_W-1:0] cmd_frame_q;
   logic cmd_frame_vld_q;
   logic remote_config_request_rej_q;
   logic [31:0] sec_cnt_q;
   logic [5:0] sec_q;
   logic [1:0] min_q;
   logic [31:0] lock_cnt_q;
   logic locked_q;
   logic [pbs_pkg::BUF_AW:0] cnt_q;
   logic [pbs_pkg::BUF_AW-1:0] wr_q;
   logic [pbs_pkg::BUF_AW-1:0] rd_q;
   logic [1:0] batch_kind_q;
   logic batch_act_q;
   logic [pbs_pkg::PAGE_W-1:0] tx_q;
   logic tx_vld_q;
   logic fetch_q;
   logic [pbs_pkg::PAGE_W-1:0] mem_rdata;
   logic wr_acc;
   logic rd_acc;
   logic page_wr;
   logic dest_hit;
   logic buf_we;
   logic [pbs_pkg::PAGE_W-1:0] stored_page;
   logic is_master;
   logic pkt_strobe;
   logic tx_pop;
   logic head_kind_ok;
   logic [1:0] head_kind;
   logic act_comm;
   logic act_p1;
   logic act_p2;
   logic [pbs_pkg::BUF_AW:0] skip_q;
   logic rot_we;

   assign wr_acc = PSEL && PENABLE && PWRITE;
   assign rd_acc = PSEL && PENABLE && !PWRITE;
   assign is_master = (ctrl_q[1:0] == 2'(pbs_pkg::PBS_ROLE_MASTER));
   assign page_wr = wr_acc && (PADDR == pbs_pkg::ADDR_PAGE_IN);
   assign pkt_strobe = wr_acc && (PADDR == pbs_pkg::ADDR_TIMEPKT);
   assign tx_pop = rd_acc && (PADDR == pbs_pkg::ADDR_TX_OUT) && tx_vld_q;

   ////////////////////////////////////////////////////////////////////////
   // Destination filter
   always_comb begin
      dest_hit = 1'b0;
      for (int i = 0; i < pbs_pkg::DEST_ENTRIES; i++) begin
         if (dest_vld_q[i] && dest_q[i] == PWDATA[pbs_pkg::DEST_W-1:0]) begin
            dest_hit = 1'b1;
         end
      end
   end

   // Internal form: destination field cleared to zero
   assign stored_page = {PWDATA[pbs_pkg::PG_KIND_HI:pbs_pkg::PG_KIND_LO], PWDATA[29:16],
                         16'h0000};
   assign buf_we = page_wr && dest_hit && (cnt_q != 5'(pbs_pkg::BUF_DEPTH));

   ////////////////////////////////////////////////////////////////////////
   // APB registers
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ctrl_q <= pbs_pkg::CTRL_RESET;
         tag_q <= '0;
         dest_vld_q <= '0;
         for (int i = 0; i < pbs_pkg::DEST_ENTRIES; i++) begin
            dest_q[i] <= '0;
         end
      end else if (wr_acc) begin
         if (PADDR == pbs_pkg::ADDR_CTRL) begin
            ctrl_q <= PWDATA[5:0];
         end
         if (PADDR == pbs_pkg::ADDR_TAG) begin
            tag_q <= PWDATA[pbs_pkg::TAG_W-1:0];
         end
         for (int i = 0; i < pbs_pkg::DEST_ENTRIES; i++) begin
            if (PADDR == pbs_pkg::ADDR_DEST0 + 8'(4 * i)) begin
               dest_q[i] <= PWDATA[pbs_pkg::DEST_W-1:0];
               dest_vld_q[i] <= PWDATA[31];
            end
         end
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         PRDATA <= 32'h0;
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY <= PSEL && !PENABLE;
         PSLVERR <= 1'b0;
         if (PSEL && !PENABLE) begin
            PRDATA <= 32'h0;
            unique case (PADDR)
               pbs_pkg::ADDR_CTRL: PRDATA <= {26'h0, ctrl_q};
               pbs_pkg::ADDR_STATUS: PRDATA <= {16'h0, remote_config_request_rej_q, batch_act_q, batch_kind_q, min_q, sec_q,
                                                tx_vld_q, locked_q, cmd_pend_q, cnt_q[4]};
               pbs_pkg::ADDR_TAG: PRDATA <= {4'h0, tag_q};
               pbs_pkg::ADDR_TX_OUT: PRDATA <= tx_q;
               default: PRDATA <= 32'h0;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Remote command handling, master only
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         cmd_frame_q <= '0;
         cmd_frame_vld_q <= 1'b0;
         cmd_pend_q <= 1'b0;
         remote_config_request_rej_q <= 1'b0;
      end else begin
         if (wr_acc && PADDR == pbs_pkg::ADDR_REMOTE_CONFIG_REQUEST) begin
            if (is_master) begin
               // Target tag in low bits, command code on top
               cmd_frame_q <= {2'(pbs_pkg::PBS_KIND_CMD), PWDATA[29:0]};
               cmd_frame_vld_q <= 1'b1;
               remote_config_request_rej_q <= 1'b0;
            end else begin
               remote_config_request_rej_q <= 1'b1;
            end
         end else if (cmd_frame_vld_q && !tx_vld_q) begin
            cmd_frame_vld_q <= 1'b0;
            cmd_pend_q <= is_master;
         end else if (wr_acc && PADDR == pbs_pkg::ADDR_CMDACK) begin
            cmd_pend_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Time base locked to time packets: second count restarts on each packet
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         sec_cnt_q <= 32'h0;
         sec_q <= 6'h0;
         min_q <= 2'h0;
         lock_cnt_q <= 32'h0;
         locked_q <= 1'b0;
      end else begin
         if (pkt_strobe) begin
            sec_cnt_q <= 32'h0;
            sec_q <= PWDATA[5:0];
            min_q <= PWDATA[9:8];
            lock_cnt_q <= 32'(pbs_pkg::LOCK_LOSS_S * pbs_pkg::SEC_TICK_CYCLES);
            locked_q <= (PWDATA[31] == ctrl_q[pbs_pkg::CTRL_SRC_GPS]);
         end else begin
            if (sec_cnt_q == 32'(pbs_pkg::SEC_TICK_CYCLES - 1)) begin
               sec_cnt_q <= 32'h0;
               if (sec_q == 6'(pbs_pkg::SEC_PER_MIN - 1)) begin
                  sec_q <= 6'h0;
                  min_q <= 2'(min_q + 2'h1);
               end else begin
                  sec_q <= 6'(sec_q + 6'h1);
               end
            end else begin
               sec_cnt_q <= sec_cnt_q + 32'h1;
            end
            if (lock_cnt_q != 32'h0) begin
               lock_cnt_q <= lock_cnt_q - 32'h1;
            end else begin
               locked_q <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Page buffer and batch scheduler
   pbs_page_mem u_mem (
      .clk(CLK),
      .we(buf_we || rot_we),
      .waddr(wr_q),
      .wdata(rot_we ? mem_rdata : stored_page),
      .raddr(rd_q),
      .rdata(mem_rdata)
   );

   assign head_kind = mem_rdata[pbs_pkg::PG_KIND_HI:pbs_pkg::PG_KIND_LO];
   // Head of another kind goes behind the batch; the rest keep their age order
   assign rot_we = fetch_q && !tx_vld_q && !cmd_frame_vld_q && !head_kind_ok && !ctrl_q[pbs_pkg::CTRL_MIX_SYNC]
                   && !page_wr;
   // Sync-format pages only at top of minute, others only afterwards
   always_comb begin
      if (ctrl_q[pbs_pkg::CTRL_MIX_SYNC]) begin
         head_kind_ok = (head_kind == 2'(pbs_pkg::PBS_KIND_SYNC4)) ? (sec_q == 6'h0) : (sec_q != 6'h0);
      end else begin
         head_kind_ok = !batch_act_q || (head_kind == batch_kind_q);
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
         batch_kind_q <= '0;
         batch_act_q <= 1'b0;
         tx_q <= '0;
         tx_vld_q <= 1'b0;
         fetch_q <= 1'b0;
         skip_q <= '0;
      end else begin
         fetch_q <= 1'b0;
         if (buf_we || rot_we) begin
            wr_q <= wr_q + 4'h1;
         end
         if (tx_pop) begin
            tx_vld_q <= 1'b0;
         end else if (cmd_frame_vld_q && !tx_vld_q) begin
            tx_q <= cmd_frame_q;
            tx_vld_q <= 1'b1;
         end else if (!tx_vld_q && cnt_q != 5'h0 && locked_q && !fetch_q) begin
            fetch_q <= 1'b1;
         end
         if (fetch_q && !tx_vld_q && !cmd_frame_vld_q) begin
            if (head_kind_ok) begin
               tx_q <= mem_rdata;
               tx_vld_q <= 1'b1;
               batch_kind_q <= head_kind;
               batch_act_q <= 1'b1;
               rd_q <= rd_q + 4'h1;
               skip_q <= '0;
            end else if (rot_we) begin
               rd_q <= rd_q + 4'h1;
               skip_q <= skip_q + 5'h1;
               batch_act_q <= (skip_q + 5'h1) < cnt_q;
            end
         end else if (cnt_q == 5'h0 && !tx_vld_q) begin
            batch_act_q <= 1'b0;
         end
         cnt_q <= cnt_q + 5'(buf_we) - 5'(fetch_q && !tx_vld_q && !cmd_frame_vld_q && head_kind_ok);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Indicators and exciter lines
   pbs_activity u_comm (.clk(CLK), .rst_n(RST_N), .din(CONSOLE_RXD), .led(act_comm));
   pbs_activity u_p1 (.clk(CLK), .rst_n(RST_N), .din(PAGING_IN_ONE_RXD), .led(act_p1));
   pbs_activity u_p2 (.clk(CLK), .rst_n(RST_N), .din(PAGING_IN_TWO_RXD), .led(act_p2));

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         PWR_LED <= 1'b0;
         CMD_LED <= 1'b0;
         SYNC_LED <= 1'b0;
         COMM_LED <= 1'b0;
         AUX_LED <= 1'b0;
         PAGING_INPUT_ONE_LED <= 1'b0;
         PAGING_INPUT_TWO_LED <= 1'b0;
         BUSY_LED <= 2'h0;
         ERROR_LED <= 2'h0;
         PTT_OUT <= 2'h0;
         PTT_LED <= 2'h0;
         CHANNEL_SELECT_ONE <= 2'h0;
         CHANNEL_SELECT_TWO <= 2'h0;
         SEL_ONE_LED <= 2'h0;
         SEL_TWO_LED <= 2'h0;
         MODE_OUT <= 1'b0;
         MODE_LED <= 1'b0;
      end else begin
         PWR_LED <= 1'b1;
         CMD_LED <= cmd_pend_q;
         SYNC_LED <= locked_q;
         COMM_LED <= act_comm;
         AUX_LED <= 1'b0;
         PAGING_INPUT_ONE_LED <= act_p1;
         PAGING_INPUT_TWO_LED <= act_p2;
         // Both ports key together; push-to-talk spans the batch
         PTT_OUT <= {2{batch_act_q}};
         PTT_LED <= {2{batch_act_q}};
         BUSY_LED <= 2'h0;
         ERROR_LED <= 2'h0;
         // Selects only move with two channels configured
         CHANNEL_SELECT_TWO <= {2{ctrl_q[pbs_pkg::CTRL_CHAN2] && batch_act_q && batch_kind_q[0]}};
         CHANNEL_SELECT_ONE <= {2{ctrl_q[pbs_pkg::CTRL_CHAN2] && batch_act_q && !batch_kind_q[0]}};
         SEL_TWO_LED <= {2{ctrl_q[pbs_pkg::CTRL_CHAN2] && batch_act_q && batch_kind_q[0]}};
         SEL_ONE_LED <= {2{ctrl_q[pbs_pkg::CTRL_CHAN2] && batch_act_q && !batch_kind_q[0]}};
         MODE_OUT <= ctrl_q[pbs_pkg::CTRL_MODE_OUT];
         MODE_LED <= ctrl_q[pbs_pkg::CTRL_MODE_OUT];
      end
   end
endmodule // pbs_top

//--- dv/pbs_chk.sv
// Checker: port-level properties of the controller core
`timescale 1ns/100ps
module pbs_chk (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic PREADY,
   input wire logic CONSOLE_RXD,
   input wire logic PAGING_IN_ONE_RXD,
   input wire logic PWR_LED,
   input wire logic CMD_LED,
   input wire logic SYNC_LED,
   input wire logic COMM_LED,
   input wire logic AUX_LED,
   input wire logic PAGING_INPUT_ONE_LED,
   input wire logic [1:0] BUSY_LED,
   input wire logic [1:0] ERROR_LED,
   input wire logic [1:0] PTT_LED,
   input wire logic [1:0] PTT_OUT,
   input wire logic [1:0] CHANNEL_SELECT_ONE,
   input wire logic [1:0] CHANNEL_SELECT_TWO,
   input wire logic [1:0] SEL_ONE_LED,
   input wire logic [1:0] SEL_TWO_LED,
   input wire logic MODE_OUT,
   input wire logic MODE_LED
);
   default clocking @(posedge CLK);
   endclocking
   default disable iff (!RST_N);
   logic wr;
   logic tp;
   assign wr = PSEL && PENABLE && PREADY && PWRITE;
   assign tp = wr && PADDR == pbs_pkg::ADDR_TIMEPKT;
   ////////////////////////////////////////////////////////////////
   a_pwr_after_rst: assert property ($past(RST_N) |-> PWR_LED)
      else $error("power lamp dark after reset");
   a_aux_dark: assert property (!AUX_LED)
      else $error("aux lamp lit");
   a_busy_err_off: assert property ((BUSY_LED | ERROR_LED) == 2'h0)
      else $error("busy or error lamp lit");
   a_ptt_mirror: assert property (PTT_LED == PTT_OUT)
      else $error("ptt lamp differs from ptt line");
   a_sel_mirror: assert property (SEL_ONE_LED == CHANNEL_SELECT_ONE && SEL_TWO_LED == CHANNEL_SELECT_TWO)
      else $error("select lamp differs from select line");
   a_mode_mirror: assert property (MODE_LED == MODE_OUT)
      else $error("mode lamp differs from mode line");
   a_sel_exclusive: assert property ((CHANNEL_SELECT_ONE & CHANNEL_SELECT_TWO) == 2'h0)
      else $error("both selects high");
   a_sel_in_batch: assert property ((|CHANNEL_SELECT_ONE) || (|CHANNEL_SELECT_TWO) |-> PTT_OUT == 2'h3)
      else $error("select high outside a batch");
   a_ack_clears: assert property (wr && PADDR == pbs_pkg::ADDR_CMDACK |-> ##[1:2] !CMD_LED)
      else $error("command lamp not cleared by ack");
   a_sync_cause: assert property ($rose(SYNC_LED) |-> $past(tp) || $past(tp, 2) || $past(tp, 3))
      else $error("lock without a time packet");
   a_comm_act: assert property ($fell(CONSOLE_RXD) |-> ##[1:5] COMM_LED)
      else $error("console activity not shown");
   a_p1_act: assert property ($fell(PAGING_IN_ONE_RXD) |-> ##[1:5] PAGING_INPUT_ONE_LED)
      else $error("paging input one activity not shown");
   a_apb_answer: assert property (PSEL && !PENABLE |=> PREADY)
      else $error("no ready in first access cycle");
endmodule // pbs_chk
bind pbs_top pbs_chk chk_u (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PADDR(PADDR), .PREADY(PREADY), .CONSOLE_RXD(CONSOLE_RXD), .PAGING_IN_ONE_RXD(PAGING_IN_ONE_RXD),
   .PWR_LED(PWR_LED), .CMD_LED(CMD_LED), .SYNC_LED(SYNC_LED), .COMM_LED(COMM_LED), .AUX_LED(AUX_LED),
   .PAGING_INPUT_ONE_LED(PAGING_INPUT_ONE_LED), .BUSY_LED(BUSY_LED), .ERROR_LED(ERROR_LED), .PTT_LED(PTT_LED),
   .PTT_OUT(PTT_OUT), .CHANNEL_SELECT_ONE(CHANNEL_SELECT_ONE), .CHANNEL_SELECT_TWO(CHANNEL_SELECT_TWO),
   .SEL_ONE_LED(SEL_ONE_LED), .SEL_TWO_LED(SEL_TWO_LED), .MODE_OUT(MODE_OUT), .MODE_LED(MODE_LED));

//--- dv/pbs_sat_rx_model.sv
// Satellite receiver model: serial paging downlink, 8N1, idle high
`timescale 1ns/100ps
module pbs_sat_rx_model #(
   parameter int BIT_CYC = 16
) (
   input wire logic clk,
   input wire logic send,
   input wire logic [7:0] data,
   output logic rxd,
   output logic busy
);
   logic [9:0] frame;
   int i;
   initial begin
      rxd = 1'b1;
      busy = 1'b0;
   end
   // Bytes pass unaltered, one fixed rate, fixed latency from send
   always begin
      @(posedge clk iff send);
      frame = {1'b1, data, 1'b0};
      busy <= 1'b1;
      for (i = 0; i < 10; i++) begin
         rxd <= frame[i];
         repeat (BIT_CYC) @(posedge clk);
      end
      busy <= 1'b0;
   end
endmodule // pbs_sat_rx_model

//--- dv/page_batch_scheduler_status_tb_top.sv
// Testbench for the paging controller core
`timescale 1ns/100ps
module page_batch_scheduler_status_tb_top;
   typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} pbs_row_t;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic con_rxd = 1'b1;
   logic aux_rxd = 1'b1;
   logic p2_rxd = 1'b1;
   logic send = 1'b0;
   logic sat_busy, p1_rxd, pready, pslverr, pwr, cmd, sync, comm, aux, p1_led, p2_led, mode_out, mode_led;
   logic [31:0] prdata, rd;
   logic [1:0] busy_led, err_led, ptt_led, ptt, channel_select_one, channel_select_two, channel_select_one_led, channel_select_two_led;
   int fails = 0;
   int check_count = 0;
   pbs_row_t rows [5];
   always #25 clk = ~clk;
   pbs_top dut_u (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .CONSOLE_RXD(con_rxd),
      .AUX_RXD(aux_rxd), .PAGING_IN_ONE_RXD(p1_rxd), .PAGING_IN_TWO_RXD(p2_rxd), .PWR_LED(pwr), .CMD_LED(cmd),
      .SYNC_LED(sync), .COMM_LED(comm), .AUX_LED(aux), .PAGING_INPUT_ONE_LED(p1_led),
      .PAGING_INPUT_TWO_LED(p2_led), .BUSY_LED(busy_led), .ERROR_LED(err_led), .PTT_LED(ptt_led), .PTT_OUT(ptt),
      .CHANNEL_SELECT_ONE(channel_select_one), .CHANNEL_SELECT_TWO(channel_select_two), .SEL_ONE_LED(channel_select_one_led), .SEL_TWO_LED(channel_select_two_led),
      .MODE_OUT(mode_out), .MODE_LED(mode_led));
   pbs_sat_rx_model sat_u (.clk(clk), .send(send), .data(8'hA5), .rxd(p1_rxd), .busy(sat_busy));
   ////////////////////////////////////////////////////////////////
   task automatic results;
      if (fails == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   // Holds the request until ready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) fails++;
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic txw(input logic [31:0] e, input logic [31:0] m, input logic [1:0] s2);
      int n;
      n = 0;
      do begin
         apb(1'b0, pbs_pkg::ADDR_STATUS, 32'h0);
         n++;
      end while (rd[3] !== 1'b1 && n < 4000);
      if (n >= 4000) fails++;
      chk("channel_select_two", {30'h0, s2}, {30'h0, channel_select_two});
      apb(1'b0, pbs_pkg::ADDR_TX_OUT, 32'h0);
      chk("tx_word", e, rd & m);
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (90000) @(posedge clk);
      fails++;
      results();
   end
   initial begin
      rows[0] = '{pbs_pkg::ADDR_TAG, 32'h01110002, 32'h01110002};
      // Table entries are write-only and read back as zero
      rows[1] = '{pbs_pkg::ADDR_DEST0, 32'h8000A801, 32'h00000000};
      rows[2] = '{8'h14, 32'h80001234, 32'h00000000};
      rows[3] = '{8'h80, 32'hFFFFFFFF, 32'h00000000};
      rows[4] = '{pbs_pkg::ADDR_CTRL, 32'h00000002, 32'h00000002};
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      chk("pwr", 32'h1, {31'h0, pwr});
      chk("leds", 32'h0, {cmd, sync, comm, p1_led, p2_led, ptt, channel_select_one, channel_select_two, mode_led});
      apb(1'b0, pbs_pkg::ADDR_STATUS, 32'h0);
      chk("status", 32'h0, rd);
      foreach (rows[i]) begin
         apb(1'b1, rows[i].a, rows[i].d);
         apb(1'b0, rows[i].a, 32'h0);
         chk("reg", rows[i].e, rd);
      end
      // Remote command refused outside master role
      apb(1'b1, pbs_pkg::ADDR_CTRL, 32'h0);
      apb(1'b1, pbs_pkg::ADDR_REMOTE_CONFIG_REQUEST, 32'h01110000);
      apb(1'b0, pbs_pkg::ADDR_STATUS, 32'h0);
      chk("reject", 32'h1, {31'h0, rd[15]});
      chk("cmd_off", 32'h0, {31'h0, cmd});
      apb(1'b1, pbs_pkg::ADDR_CTRL, 32'h1);
      apb(1'b1, pbs_pkg::ADDR_REMOTE_CONFIG_REQUEST, 32'h01110000);
      txw(32'hC0000000, 32'hC0000000, 2'h0);
      chk("cmd_on", 32'h1, {31'h0, cmd});
      apb(1'b1, pbs_pkg::ADDR_CMDACK, 32'h0);
      repeat (3) @(posedge clk);
      chk("cmd_ack", 32'h0, {31'h0, cmd});
      // Two channels, mode line, positioning time source
      apb(1'b1, pbs_pkg::ADDR_CTRL, 32'h00000034);
      repeat (3) @(posedge clk);
      chk("mode", 32'h1, {31'h0, mode_led});
      apb(1'b1, pbs_pkg::ADDR_PAGE_IN, 32'h0001A801);
      apb(1'b1, pbs_pkg::ADDR_PAGE_IN, 32'h4002A801);
      apb(1'b1, pbs_pkg::ADDR_PAGE_IN, 32'h0003A801);
      apb(1'b1, pbs_pkg::ADDR_PAGE_IN, 32'h00045555);
      apb(1'b1, pbs_pkg::ADDR_TIMEPKT, 32'h0);
      repeat (4) @(posedge clk);
      chk("sync_wrong_src", 32'h0, {31'h0, sync});
      apb(1'b1, pbs_pkg::ADDR_TIMEPKT, 32'h80000205);
      repeat (4) @(posedge clk);
      chk("sync", 32'h1, {31'h0, sync});
      apb(1'b0, pbs_pkg::ADDR_STATUS, 32'h0);
      chk("time", 32'h00000854, rd & 32'h00000FF4);
      txw(32'h00010000, 32'hFFFFFFFF, 2'h0);
      txw(32'h00030000, 32'hFFFFFFFF, 2'h0);
      txw(32'h40020000, 32'hFFFFFFFF, 2'h3);
      repeat (200) @(posedge clk);
      apb(1'b0, pbs_pkg::ADDR_STATUS, 32'h0);
      chk("no_miss_page", 32'h0, {31'h0, rd[3]});
      // Sync-format page held until the top of the minute
      apb(1'b1, pbs_pkg::ADDR_CTRL, 32'h00000028);
      apb(1'b1, pbs_pkg::ADDR_TIMEPKT, 32'h80000005);
      apb(1'b1, pbs_pkg::ADDR_PAGE_IN, 32'h8005A801);
      repeat (20) @(posedge clk);
      apb(1'b0, pbs_pkg::ADDR_STATUS, 32'h0);
      chk("sync_fmt_held", 32'h0, {31'h0, rd[3]});
      apb(1'b1, pbs_pkg::ADDR_TIMEPKT, 32'h80000000);
      txw(32'h80050000, 32'hFFFFFFFF, 2'h0);
      // Line activity on every input
      send <= 1'b1;
      con_rxd <= 1'b0;
      p2_rxd <= 1'b0;
      aux_rxd <= 1'b0;
      @(posedge clk);
      send <= 1'b0;
      repeat (8) @(posedge clk);
      con_rxd <= 1'b1;
      p2_rxd <= 1'b1;
      aux_rxd <= 1'b1;
      for (int n = 0; n < 400 && sat_busy !== 1'b0; n++) @(posedge clk);
      chk("activity", 32'hE, {28'h0, comm, p1_led, p2_led, aux});
      // Reset in mid-run
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      chk("rst_leds", 32'h0, {pwr, cmd, sync, comm, p1_led, p2_led, ptt_led, ptt, channel_select_one, channel_select_two, mode_out});
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      apb(1'b0, pbs_pkg::ADDR_STATUS, 32'h0);
      chk("rst_status", 32'h0, rd);
      apb(1'b0, pbs_pkg::ADDR_CTRL, 32'h0);
      chk("rst_ctrl", {26'h0, pbs_pkg::CTRL_RESET}, rd);
      results();
   end
endmodule // page_batch_scheduler_status_tb_top
